// ==== src/gcs_pkg.sv ====
// package: constants and types for the gauge command and status registers
package gcs_pkg;
   localparam logic [6:0] ADDR_PRIMARY_FLAGS = 7'h01;
   localparam logic [6:0] ADDR_TEMP_GAUGE = 7'h02;
   localparam logic [6:0] ADDR_CHARGE_HIGH = 7'h03;
   localparam logic [6:0] ADDR_PACK_IDENT = 7'h04;
   localparam logic [6:0] ADDR_FULL_REF = 7'h05;
   localparam logic [6:0] ADDR_SECONDARY_FLAGS = 7'h06;
   localparam logic [6:0] ADDR_PULLDOWN_SEEN = 7'h07;
   localparam logic [6:0] ADDR_PULLUP_SEEN = 7'h08;
   localparam logic [6:0] ADDR_OUTPUT_OVERRIDE = 7'h0A;
   localparam logic [6:0] ADDR_OFFSET_ADJUST = 7'h0B;
   localparam logic [6:0] ADDR_SELF_DISCHARGE = 7'h0C;
   localparam logic [6:0] ADDR_MAG_FILTER = 7'h0D;
   localparam logic [6:0] ADDR_SMALL_LOAD = 7'h0E;
   localparam logic [6:0] ADDR_FAST_CHARGE = 7'h0F;
   localparam logic [6:0] ADDR_CHARGE_LOW = 7'h17;
   localparam logic [6:0] ADDR_PROGRAM_PIN = 7'h1E;
   localparam logic [6:0] ADDR_BATTERY_VOLT = 7'h7E;
   localparam int CMD_DIR_BIT = 7;
   localparam int BYTE_BITS = 8;
   localparam int FLAG_CHARGE_BIT = 7;
   localparam int FLAG_PACK_RESET_BIT = 6;
   localparam int FLAG_QUAL_DIS_BIT = 3;
   localparam int FLAG_FIRST_EMPTY_BIT = 1;
   localparam int FLAG_FINAL_EMPTY_BIT = 0;
   localparam int OVR_ENABLE_BIT = 1;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] FULL_REF_RESET = 8'h00;
   localparam logic [7:0] MAG_FILTER_RESET = 8'h00;
   localparam logic [7:0] TEMP_BAND_BASE = 8'h00;
   localparam logic [7:0] TEMP_BAND_STEP = 8'h0A;
   localparam logic [3:0] TEMP_CODE_MAX = 4'hC;
   localparam logic [7:0] FINAL_EMPTY_DROP = 8'h0A;
   localparam logic [7:0] SELF_DIS_PCT = 8'h06;
   localparam logic [7:0] ZERO_C_CODE = 8'h1E;
   localparam int CLK_MHZ = 100;
   localparam int EMPTY_DELAY_MS = 1000;
   localparam int EMPTY_DELAY_CYC = EMPTY_DELAY_MS * CLK_MHZ * 1000;
   localparam int BLINK_HZ = 4;
   localparam int BLINK_HALF_CYC = CLK_MHZ * 1000000 / (BLINK_HZ * 2);
   localparam int TOTAL_BLINK_BITS = 25;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } gcs_byte_t;

   typedef struct packed {
      logic update;
      logic charging;
      logic discharging;
      logic sense_above;
      logic self_dis;
   } gcs_count_t;
endpackage

// ==== src/gcs_shift_in.sv ====
// module: serial byte assembler, lsb first
`timescale 1ns/10ps
module gcs_shift_in
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic restart_i,
   input wire logic bit_valid_i,
   input wire logic bit_i,
   output gcs_pkg::gcs_byte_t byte_o
);
   logic [7:0] shift;
   logic [3:0] count;

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         shift <= gcs_pkg::RESET_BYTE;
         count <= 4'h0;
         byte_o <= '0;
      end
      else
      begin
         byte_o.valid <= 1'b0;
         if (restart_i)
         begin
            count <= 4'h0;
         end
         else if (bit_valid_i)
         begin
            shift <= {bit_i, shift[7:1]};
            if (count == 4'(gcs_pkg::BYTE_BITS - 1))
            begin
               count <= 4'h0;
               byte_o.valid <= 1'b1;
               byte_o.data <= {bit_i, shift[7:1]};
            end
            else
            begin
               count <= count + 4'h1;
            end
         end
      end
   end
endmodule // gcs_shift_in

// ==== src/gcs_regs.sv ====
// module: command decoder, register map and primary flag logic
`timescale 1ns/10ps
module gcs_regs
#(
   parameter int EMPTY_DELAY_CYC = gcs_pkg::EMPTY_DELAY_CYC,
   parameter int BLINK_HALF_CYC = gcs_pkg::BLINK_HALF_CYC
)
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic serial_reset_i,
   input wire logic frame_break_i,
   input wire logic bit_valid_i,
   input wire logic bit_i,
   input wire logic tx_ready_i,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire gcs_pkg::gcs_count_t count_i,
   input wire logic [15:0] available_charge_count_i,
   input wire logic [7:0] temperature_i,
   input wire logic [3:0] gauge_code_i,
   input wire logic [7:0] battery_sense_voltage_i,
   input wire logic [7:0] first_empty_threshold_i,
   input wire logic overload_flag_i,
   input wire logic charge_rate_i,
   input wire logic [5:0] pulldown_seen_i,
   input wire logic [5:0] pullup_seen_i,
   input wire logic full_ref_update_i,
   input wire logic [4:0] display_i,
   output logic [4:0] segment_o,
   output logic done_low_o,
   output logic [7:0] full_reference_o,
   output logic [15:0] charge_write_o,
   output logic charge_write_valid_o
);
   typedef enum logic [1:0] {
      GCS_CMD = 2'b00,
      GCS_DATA = 2'b01,
      GCS_SEND = 2'b10
   } gcs_state_t;

   gcs_state_t state;
   gcs_pkg::gcs_byte_t rx;
   logic [7:0] command;
   logic [7:0] read_value;
   logic [7:0] pack_ident;
   logic [7:0] output_override;
   logic [7:0] offset_adjust;
   logic [7:0] self_discharge_rate;
   logic [7:0] magnitude_filter;
   logic [7:0] small_load_comp;
   logic [7:0] fast_charge_comp;
   logic [7:0] program_pin_data;
   logic charge_active_flag;
   logic pack_reset_flag;
   logic qualified_discharge_flag;
   logic first_empty_warning;
   logic final_empty_warning;
   logic [7:0] primary_flags;
   logic [7:0] temp_and_gauge;
   logic [3:0] temp_code;
   logic [1:0] above_count;
   logic valid_charge;
   logic [15:0] qual_mark;
   logic [31:0] empty_timer;
   logic [31:0] blink_timer;
   logic blink;
   logic write_hit;
   logic [7:0] final_threshold;
   logic [15:0] self_dis_limit;
   logic first_below;
   logic final_below;

   gcs_shift_in u_shift
   (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .restart_i(frame_break_i),
      .bit_valid_i(bit_valid_i),
      .bit_i(bit_i),
      .byte_o(rx)
   );

   // command and data sequencing
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state <= GCS_CMD;
         command <= gcs_pkg::RESET_BYTE;
         tx_valid_o <= 1'b0;
         tx_data_o <= gcs_pkg::RESET_BYTE;
      end
      else if (serial_reset_i || frame_break_i)
      begin
         state <= GCS_CMD;
         tx_valid_o <= 1'b0;
      end
      else
      begin
         case (state)
            GCS_CMD:
            begin
               if (rx.valid)
               begin
                  command <= rx.data;
                  if (rx.data[gcs_pkg::CMD_DIR_BIT])
                  begin
                     state <= GCS_DATA;
                  end
                  else
                  begin
                     state <= GCS_SEND;
                  end
               end
            end
            GCS_DATA:
            begin
               if (rx.valid)
               begin
                  state <= GCS_CMD;
               end
            end
            GCS_SEND:
            begin
               tx_valid_o <= 1'b1;
               if (!tx_valid_o)
               begin
                  tx_data_o <= read_value;
               end
               if (tx_valid_o && tx_ready_i)
               begin
                  tx_valid_o <= 1'b0;
                  state <= GCS_CMD;
               end
            end
            default:
            begin
               state <= GCS_CMD;
            end
         endcase
      end
   end

   assign write_hit = (state == GCS_DATA) && rx.valid && !serial_reset_i &&
      !frame_break_i;

   // writable registers; read-only and unmapped addresses fall through
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pack_ident <= gcs_pkg::RESET_BYTE;
         full_reference_o <= gcs_pkg::FULL_REF_RESET;
         output_override <= gcs_pkg::RESET_BYTE;
         offset_adjust <= gcs_pkg::RESET_BYTE;
         self_discharge_rate <= gcs_pkg::RESET_BYTE;
         magnitude_filter <= gcs_pkg::MAG_FILTER_RESET;
         small_load_comp <= gcs_pkg::RESET_BYTE;
         fast_charge_comp <= gcs_pkg::RESET_BYTE;
         program_pin_data <= gcs_pkg::RESET_BYTE;
         charge_write_o <= 16'h0000;
         charge_write_valid_o <= 1'b0;
      end
      else if (serial_reset_i)
      begin
         output_override <= gcs_pkg::RESET_BYTE;
         charge_write_o <= 16'h0000;
         charge_write_valid_o <= 1'b1;
      end
      else
      begin
         charge_write_valid_o <= 1'b0;
         if (write_hit)
         begin
            case (command[6:0])
               gcs_pkg::ADDR_CHARGE_HIGH:
               begin
                  charge_write_o <= {rx.data, available_charge_count_i[7:0]};
                  charge_write_valid_o <= 1'b1;
               end
               gcs_pkg::ADDR_CHARGE_LOW:
               begin
                  charge_write_o <= {available_charge_count_i[15:8], rx.data};
                  charge_write_valid_o <= 1'b1;
               end
               gcs_pkg::ADDR_PACK_IDENT: pack_ident <= rx.data;
               gcs_pkg::ADDR_FULL_REF: full_reference_o <= rx.data;
               gcs_pkg::ADDR_OUTPUT_OVERRIDE: output_override <= rx.data;
               gcs_pkg::ADDR_OFFSET_ADJUST: offset_adjust <= rx.data;
               gcs_pkg::ADDR_SELF_DISCHARGE: self_discharge_rate <= rx.data;
               gcs_pkg::ADDR_MAG_FILTER: magnitude_filter <= rx.data;
               gcs_pkg::ADDR_SMALL_LOAD: small_load_comp <= rx.data;
               gcs_pkg::ADDR_FAST_CHARGE: fast_charge_comp <= rx.data;
               gcs_pkg::ADDR_PROGRAM_PIN: program_pin_data <= rx.data;
               default:
               begin
                  charge_write_valid_o <= 1'b0;
               end
            endcase
         end
      end
   end

   // read multiplexer
   always_comb
   begin
      case (command[6:0])
         gcs_pkg::ADDR_PRIMARY_FLAGS: read_value = primary_flags;
         gcs_pkg::ADDR_TEMP_GAUGE: read_value = temp_and_gauge;
         gcs_pkg::ADDR_CHARGE_HIGH: read_value = available_charge_count_i[15:8];
         gcs_pkg::ADDR_CHARGE_LOW: read_value = available_charge_count_i[7:0];
         gcs_pkg::ADDR_PACK_IDENT: read_value = pack_ident;
         gcs_pkg::ADDR_FULL_REF: read_value = full_reference_o;
         gcs_pkg::ADDR_SECONDARY_FLAGS:
            read_value = {charge_rate_i, 6'h00, overload_flag_i};
         gcs_pkg::ADDR_PULLDOWN_SEEN: read_value = {2'h0, pulldown_seen_i};
         gcs_pkg::ADDR_PULLUP_SEEN: read_value = {2'h0, pullup_seen_i};
         gcs_pkg::ADDR_OUTPUT_OVERRIDE: read_value = output_override;
         gcs_pkg::ADDR_OFFSET_ADJUST: read_value = offset_adjust;
         gcs_pkg::ADDR_SELF_DISCHARGE: read_value = self_discharge_rate;
         gcs_pkg::ADDR_MAG_FILTER: read_value = magnitude_filter;
         gcs_pkg::ADDR_SMALL_LOAD: read_value = small_load_comp;
         gcs_pkg::ADDR_FAST_CHARGE: read_value = fast_charge_comp;
         gcs_pkg::ADDR_PROGRAM_PIN: read_value = 8'h00;
         gcs_pkg::ADDR_BATTERY_VOLT: read_value = battery_sense_voltage_i;
         default: read_value = 8'h00;
      endcase
   end

   // temperature band encoder
   always_comb
   begin
      if (temperature_i < gcs_pkg::TEMP_BAND_STEP)
      begin
         temp_code = 4'h0;
      end
      else if (temperature_i / gcs_pkg::TEMP_BAND_STEP >
         8'(gcs_pkg::TEMP_CODE_MAX))
      begin
         temp_code = gcs_pkg::TEMP_CODE_MAX;
      end
      else
      begin
         temp_code = 4'(temperature_i / gcs_pkg::TEMP_BAND_STEP);
      end
   end

   assign temp_and_gauge = {temp_code, gauge_code_i};
   assign primary_flags = {charge_active_flag, pack_reset_flag, 2'b00,
      qualified_discharge_flag, 1'b0, first_empty_warning,
      final_empty_warning};

   // valid charge: two successive updates above threshold
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         above_count <= 2'h0;
         charge_active_flag <= 1'b0;
      end
      else if (serial_reset_i || count_i.discharging || !count_i.sense_above)
      begin
         above_count <= 2'h0;
         charge_active_flag <= 1'b0;
      end
      else if (count_i.update && count_i.charging)
      begin
         if (above_count != 2'h2)
         begin
            above_count <= above_count + 2'h1;
         end
         if (above_count == 2'h1)
         begin
            charge_active_flag <= 1'b1;
         end
      end
   end

   assign valid_charge = charge_active_flag;

   // pack reset flag
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pack_reset_flag <= 1'b1;
      end
      else if (serial_reset_i)
      begin
         pack_reset_flag <= 1'b1;
      end
      else if (valid_charge && (first_empty_warning ||
         available_charge_count_i[7:0] == full_reference_o))
      begin
         pack_reset_flag <= 1'b0;
      end
   end

   assign self_dis_limit = 16'(({8'h00, full_reference_o} *
      {8'h00, gcs_pkg::SELF_DIS_PCT}) / 16'h0064);

   // qualified discharge flag
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         qualified_discharge_flag <= 1'b0;
         qual_mark <= 16'h0000;
      end
      else if (serial_reset_i || full_ref_update_i || valid_charge ||
         (first_empty_warning && temperature_i < gcs_pkg::ZERO_C_CODE) ||
         (qualified_discharge_flag &&
         qual_mark - available_charge_count_i > self_dis_limit))
      begin
         qualified_discharge_flag <= 1'b0;
      end
      else if (!qualified_discharge_flag && count_i.discharging &&
         available_charge_count_i[7:0] == full_reference_o)
      begin
         qualified_discharge_flag <= 1'b1;
         qual_mark <= available_charge_count_i;
      end
   end

   assign final_threshold = first_empty_threshold_i - gcs_pkg::FINAL_EMPTY_DROP;
   assign first_below = battery_sense_voltage_i < first_empty_threshold_i;
   assign final_below = battery_sense_voltage_i < final_threshold;

   // empty warnings
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         empty_timer <= 32'h0;
         first_empty_warning <= 1'b0;
         final_empty_warning <= 1'b0;
      end
      else if (serial_reset_i || valid_charge)
      begin
         empty_timer <= 32'h0;
         first_empty_warning <= 1'b0;
         final_empty_warning <= 1'b0;
      end
      else
      begin
         if (!first_below || overload_flag_i)
         begin
            empty_timer <= 32'h0;
         end
         else if (empty_timer == 32'(EMPTY_DELAY_CYC - 1))
         begin
            first_empty_warning <= 1'b1;
         end
         else
         begin
            empty_timer <= empty_timer + 32'h1;
         end
         if (final_below && !overload_flag_i)
         begin
            final_empty_warning <= 1'b1;
         end
      end
   end

   // blink divider
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         blink_timer <= 32'h0;
         blink <= 1'b0;
      end
      else if (blink_timer == 32'(BLINK_HALF_CYC - 1))
      begin
         blink_timer <= 32'h0;
         blink <= ~blink;
      end
      else
      begin
         blink_timer <= blink_timer + 32'h1;
      end
   end

   // segment and done outputs
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         segment_o <= 5'h00;
         done_low_o <= 1'b0;
      end
      else
      begin
         done_low_o <= first_empty_warning;
         if (output_override[gcs_pkg::OVR_ENABLE_BIT])
         begin
            segment_o <= output_override[6:2];
         end
         else if (final_empty_warning)
         begin
            segment_o <= 5'h00;
         end
         else if (first_empty_warning)
         begin
            segment_o <= {display_i[4:1], blink};
         end
         else
         begin
            segment_o <= display_i;
         end
      end
   end
endmodule // gcs_regs

// ==== testbench/gcs_regs_chk.sv ====
// checker: port-level assertions for the register block
`timescale 1ns/10ps
module gcs_regs_chk
#(
   parameter int EMPTY_DELAY_CYC = gcs_pkg::EMPTY_DELAY_CYC,
   parameter int BLINK_HALF_CYC = gcs_pkg::BLINK_HALF_CYC
)
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic serial_reset_i,
   input wire logic bit_valid_i,
   input wire logic tx_ready_i,
   input wire logic tx_valid_o,
   input wire logic [7:0] tx_data_o,
   input wire logic [7:0] battery_sense_voltage_i,
   input wire logic [7:0] first_empty_threshold_i,
   input wire logic overload_flag_i,
   input wire logic [4:0] segment_o,
   input wire logic done_low_o,
   input wire logic [7:0] full_reference_o,
   input wire logic [15:0] charge_write_o,
   input wire logic charge_write_valid_o
);
   int below_cnt;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   // cycles spent below the first threshold with no overload
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         below_cnt <= 0;
      else if (battery_sense_voltage_i < first_empty_threshold_i &&
               !overload_flag_i)
         below_cnt <= (below_cnt < 1000) ? below_cnt + 1 : below_cnt;
      else
         below_cnt <= 0;
   end
   tx_hold_a: assert property (
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("read byte dropped before the host took it");
   tx_drop_a: assert property (
      tx_valid_o && tx_ready_i |=> !tx_valid_o)
      else $error("read byte still offered after handshake");
   tx_after_byte_a: assert property (
      $rose(tx_valid_o) |-> $past(bit_valid_i, 3))
      else $error("read answer not three cycles after a bit");
   done_delay_a: assert property (
      $rose(done_low_o) |-> below_cnt >= EMPTY_DELAY_CYC - 1)
      else $error("empty warning before the delay time");
   done_overload_flag_a: assert property (
      $rose(done_low_o) |-> !$past(overload_flag_i, 2))
      else $error("empty warning raised during overload");
   final_blank_a: assert property (
      (({1'b0, battery_sense_voltage_i} + 9'h00A <
        {1'b0, first_empty_threshold_i}) && !overload_flag_i) [*3]
      |-> segment_o == 5'h00)
      else $error("segments lit below final threshold");
   sreset_zero_a: assert property (
      serial_reset_i |-> ##[1:2] charge_write_valid_o &&
      charge_write_o == 16'h0000)
      else $error("serial reset did not zero the charge");
   wr_pulse_a: assert property (
      charge_write_valid_o |=> !charge_write_valid_o)
      else $error("charge write strobe longer than one cycle");
   lmd_cause_a: assert property (
      $changed(full_reference_o) |-> $past(bit_valid_i, 2) ||
      $past(serial_reset_i) || $past(serial_reset_i, 2))
      else $error("full reference changed without a write");
   read_cov_c: cover property (tx_valid_o && tx_ready_i);
   warn_cov_c: cover property ($rose(done_low_o));
   sreset_cov_c: cover property (charge_write_valid_o);
endmodule // gcs_regs_chk

bind gcs_regs gcs_regs_chk #(
   .EMPTY_DELAY_CYC(EMPTY_DELAY_CYC), .BLINK_HALF_CYC(BLINK_HALF_CYC)
) i_gcs_regs_chk (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .serial_reset_i(serial_reset_i),
   .bit_valid_i(bit_valid_i), .tx_ready_i(tx_ready_i),
   .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
   .battery_sense_voltage_i(battery_sense_voltage_i),
   .first_empty_threshold_i(first_empty_threshold_i),
   .overload_flag_i(overload_flag_i), .segment_o(segment_o),
   .done_low_o(done_low_o), .full_reference_o(full_reference_o),
   .charge_write_o(charge_write_o),
   .charge_write_valid_o(charge_write_valid_o)
);

// ==== testbench/gcs_host.sv ====
// model: host processor on the serial link
`timescale 1ns/10ps
module gcs_host
(
   input wire logic clk_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic bit_valid_o,
   output logic bit_o,
   output logic tx_ready_o,
   output logic frame_break_o
);
   initial
   begin
      bit_valid_o = 1'b0;
      bit_o = 1'b1;
      tx_ready_o = 1'b0;
      frame_break_o = 1'b0;
   end
   // lsb first, one bit every other cycle; idle line shows inverse
   task automatic send_bits(input logic [7:0] d, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(negedge clk_i);
         bit_o = d[i];
         bit_valid_o = 1'b1;
         @(negedge clk_i);
         bit_valid_o = 1'b0;
         bit_o = ~bit_o;
      end
   endtask
   task automatic send_byte(input logic [7:0] d);
      send_bits(d, 8);
   endtask
   task automatic abort_frame();
      @(negedge clk_i);
      frame_break_o = 1'b1;
      @(negedge clk_i);
      frame_break_o = 1'b0;
   endtask
   // waits for the byte, stalls, then takes it at a rising edge
   task automatic take_byte(input int stall, output logic [7:0] d,
                            output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      d = 8'h00;
      while (tx_valid_i !== 1'b1 && n < 50)
      begin
         @(negedge clk_i);
         n++;
      end
      if (tx_valid_i === 1'b1)
      begin
         repeat (stall) @(negedge clk_i);
         tx_ready_o = 1'b1;
         @(posedge clk_i);
         d = tx_data_i;
         ok = 1'b1;
         @(negedge clk_i);
         tx_ready_o = 1'b0;
      end
   endtask
endmodule // gcs_host

// ==== testbench/gcs_regs_tb.sv ====
// testbench: register block driven by the host model
`timescale 1ns/10ps
module gcs_regs_tb;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic s_reset = 1'b0;
   logic brk, bit_v, bit_d, tx_rdy, tx_val, done_low, cw_val;
   logic [7:0] tx_d, full_ref;
   logic [15:0] cw;
   logic [4:0] seg;
   gcs_pkg::gcs_count_t count = '0;
   logic [7:0] temp = 8'hFF;
   logic [3:0] gauge = 4'h5;
   logic [7:0] batt = 8'h80;
   logic overload_flag = 1'b0;
   logic rate = 1'b1;
   logic [4:0] disp = 5'h0A;
   logic [15:0] avail = 16'h1234;
   logic lmd_upd = 1'b0;
   int bad_count = 0;
   int n_compared = 0;
   int cycles = 0;
   gcs_regs #(.EMPTY_DELAY_CYC(20), .BLINK_HALF_CYC(4)) i_gcs_regs (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .serial_reset_i(s_reset),
      .frame_break_i(brk), .bit_valid_i(bit_v), .bit_i(bit_d),
      .tx_ready_i(tx_rdy), .tx_valid_o(tx_val), .tx_data_o(tx_d),
      .count_i(count), .available_charge_count_i(avail),
      .temperature_i(temp), .gauge_code_i(gauge),
      .battery_sense_voltage_i(batt), .first_empty_threshold_i(8'h40),
      .overload_flag_i(overload_flag), .charge_rate_i(rate),
      .pulldown_seen_i(6'h3F), .pullup_seen_i(6'h15),
      .full_ref_update_i(lmd_upd), .display_i(disp), .segment_o(seg),
      .done_low_o(done_low), .full_reference_o(full_ref),
      .charge_write_o(cw), .charge_write_valid_o(cw_val));
   gcs_host i_gcs_host (.clk_i(clk_i), .tx_valid_i(tx_val),
      .tx_data_i(tx_d), .bit_valid_o(bit_v), .bit_o(bit_d),
      .tx_ready_o(tx_rdy), .frame_break_o(brk));
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      i_gcs_host.send_byte({1'b0, a});
      i_gcs_host.take_byte(a[0] ? 3 : 0, d, ok);
      check({15'h0000, ok}, 16'h0001);
      check({8'h00, d}, {8'h00, exp});
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      i_gcs_host.send_byte({1'b1, a});
      i_gcs_host.send_byte(v);
      repeat (3) @(negedge clk_i);
   endtask
   task automatic upd(input logic chg, input logic dis);
      @(negedge clk_i);
      count = {1'b1, chg, dis, chg, 1'b0};
      @(negedge clk_i);
      count.update = 1'b0;
   endtask
   task automatic t_map();
      logic [6:0] a[8] = '{7'h01, 7'h02, 7'h06, 7'h07, 7'h08, 7'h09,
                           7'h1E, 7'h7E};
      logic [7:0] e[8] = '{8'h40, 8'hC5, 8'h80, 8'h3F, 8'h15, 8'h00,
                           8'h00, 8'h80};
      for (int i = 0; i < 8; i++)
         rd(a[i], e[i]);
      temp = 8'h00;
      gauge = 4'hA;
      rate = 1'b0;
      overload_flag = 1'b1;
      rd(7'h02, 8'h0A);
      rd(7'h06, 8'h01);
      overload_flag = 1'b0;
      temp = 8'hFF;
      $display("test map done");
   endtask
   task automatic t_write();
      wr(7'h04, 8'hA5);
      rd(7'h04, 8'hA5);
      wr(7'h01, 8'hFF);
      wr(7'h09, 8'h5A);
      rd(7'h01, 8'h40);
      rd(7'h09, 8'h00);
      wr(7'h05, 8'h3C);
      check({8'h00, full_ref}, 16'h003C);
      wr(7'h03, 8'h56);
      check(cw, 16'h5634);
      wr(7'h17, 8'h78);
      check(cw, 16'h1278);
      i_gcs_host.send_bits(8'h84, 4);
      i_gcs_host.abort_frame();
      rd(7'h04, 8'hA5);
      $display("test write done");
   endtask
   task automatic t_override();
      check({11'h000, seg}, 16'h000A);
      wr(7'h0A, 8'hD6);
      check({11'h000, seg}, 16'h0015);
      wr(7'h0A, 8'h00);
      check({11'h000, seg}, 16'h000A);
      $display("test override done");
   endtask
   task automatic t_flags();
      logic b;
      upd(1'b1, 1'b0);
      upd(1'b1, 1'b0);
      rd(7'h01, 8'hC0);
      upd(1'b0, 1'b1);
      rd(7'h01, 8'h40);
      disp = 5'h1F;
      overload_flag = 1'b1;
      batt = 8'h38;
      repeat (40) @(negedge clk_i);
      check({15'h0000, done_low}, 16'h0000);
      overload_flag = 1'b0;
      repeat (40) @(negedge clk_i);
      check({15'h0000, done_low}, 16'h0001);
      b = seg[0];
      repeat (4) @(negedge clk_i);
      check({15'h0000, seg[0]}, {15'h0000, ~b});
      rd(7'h01, 8'h42);
      batt = 8'h20;
      repeat (5) @(negedge clk_i);
      check({11'h000, seg}, 16'h0000);
      rd(7'h01, 8'h43);
      batt = 8'h80;
      upd(1'b1, 1'b0);
      upd(1'b1, 1'b0);
      rd(7'h01, 8'h80);
      check({15'h0000, done_low}, 16'h0000);
      $display("test flags done");
   endtask
   task automatic t_sreset();
      upd(1'b0, 1'b1);
      wr(7'h0A, 8'hD6);
      @(negedge clk_i);
      s_reset = 1'b1;
      @(negedge clk_i);
      s_reset = 1'b0;
      repeat (3) @(negedge clk_i);
      check({11'h000, seg}, 16'h001F);
      check(cw, 16'h0000);
      rd(7'h01, 8'h40);
      avail = 16'h123C;
      upd(1'b0, 1'b1);
      rd(7'h01, 8'h48);
      avail = 16'h1230;
      rd(7'h01, 8'h40);
      avail = 16'h123C;
      repeat (2) @(negedge clk_i);
      avail = 16'h123B;
      rd(7'h01, 8'h48);
      lmd_upd = 1'b1;
      @(negedge clk_i);
      lmd_upd = 1'b0;
      rd(7'h01, 8'h40);
      $display("test serial reset done");
   endtask
   initial
   begin
      repeat (12) @(negedge clk_i);
      reset_n_i = 1'b1;
      t_map();
      t_write();
      t_override();
      t_flags();
      t_sreset();
      finish_test();
   end
endmodule // gcs_regs_tb
